// ### hdl/cssr_pkg.sv
package cssr_pkg;

  // Configuration fuses, one means unprogrammed
  typedef struct packed {
    logic       div8;
    logic [1:0] sut;
    logic [3:0] cksel;
  } cssr_fuse_t;

  // Clock source kinds
  typedef enum logic [2:0] {
    SRC_LP_XTAL, SRC_FS_XTAL, SRC_LF_XTAL, SRC_RC128,
    SRC_RC_CAL, SRC_EXT, SRC_RSVD
  } cssr_src_t;

  // Sleep modes written by software
  typedef enum logic [2:0] {
    MODE_ACTIVE, MODE_IDLE, MODE_ADC_NR, MODE_PWR_DOWN, MODE_PWR_SAVE
  } cssr_mode_t;

  // Start-up sequencer states
  typedef enum logic [2:0] {
    ST_HOLD, ST_TOUT, ST_START, ST_RUN, ST_SLEEP
  } cssr_state_t;

  // Domain gate enables
  typedef struct packed {
    logic core;
    logic nvm;
    logic periph;
    logic async;
    logic conv;
  } cssr_gate_t;

endpackage : cssr_pkg

// ### hdl/cssr_regs.svh
// Overview of operation
// - Four-bit source select maps codes to sources
// - Fuse bit one unprogrammed, zero programmed
// - Delivered: RC 0010, start-up 10, divide-by-eight
// - Extra watchdog-timed delay after other resets release
// - Time-out lengths 0, 4096 or 8192 cycles
// - Ripple counter holds reset for start-up count
// - Reset: time-out plus start-up; power-down/save wake: start-up, idle wake: none
// - Upper select bits pick low power range
// - Resonator start-up and delay from select bits
// - Crystal settings give 258, 1K, 16K or 32K cycle start-up
// - Start-up counts from 6 to 32K cycles
// - Core clock stop freezes core; flash follows
// - Peripheral clock; wake events seen while halted
// - Async timer domain keeps counting in sleep except power-down
// - Converter domain runs with core stopped
`ifndef CSSR_REGS_SVH
`define CSSR_REGS_SVH

//------------------------------------------------------------
// Register byte offsets
//------------------------------------------------------------
`define CSSR_FUSE_OFS   8'h00
`define CSSR_CTRL_OFS   8'h04
`define CSSR_STAT_OFS   8'h08

//------------------------------------------------------------
// Field positions and reset values
//------------------------------------------------------------
`define CSSR_SUT_LSB    4
`define CSSR_DIV8_BIT   6
`define CSSR_FUSE_RST   7'h22
`define CSSR_MODE_RST   3'h0

//------------------------------------------------------------
// Start-up counts in oscillator cycles
//------------------------------------------------------------
`define CSSR_SU_EXT     17'h00006
`define CSSR_SU_258     17'h00102
`define CSSR_SU_1K      17'h00400
`define CSSR_ADD_CK     17'h0000E
`define CSSR_SU_16K     16384
`define CSSR_SU_32K     32768

//------------------------------------------------------------
// Time-out counts in watchdog cycles
//------------------------------------------------------------
`define CSSR_TOUT_SHORT 4096
`define CSSR_TOUT_LONG  8192

`endif

// ### hdl/cssr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cssr_regs.svh"

module cssr_top
  import cssr_pkg::*;
#(
  parameter int TOUT_SHORT = `CSSR_TOUT_SHORT,
  parameter int TOUT_LONG  = `CSSR_TOUT_LONG,
  parameter int SU_16K     = `CSSR_SU_16K,
  parameter int SU_32K     = `CSSR_SU_32K
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Pins from outside the clock domain
  input  wire logic        osc_in_pin,
  input  wire logic        wdt_osc_pin,
  input  wire logic        async_osc_pin,
  input  wire logic        rst_src_n,
  input  wire logic        wake_pin,
  // Reset and gated clocks
  output logic             int_rst_n,
  output logic             core_clk,
  output logic             nvm_if_clk,
  output logic             periph_clk,
  output logic             async_timer_clk,
  output logic             converter_clk
);

  //----------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic       osc_d;
  logic       wdt_d;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      osc_d <= 1'b0;
      wdt_d <= 1'b0;
    end else begin
      sync1 <= {wake_pin, rst_src_n, async_osc_pin, wdt_osc_pin, osc_in_pin};
      sync2 <= sync1;
      osc_d <= sync2[0];
      wdt_d <= sync2[1];
    end
  end

  wire osc_s   = sync2[0];
  wire async_s = sync2[2];
  wire src_ok  = sync2[3];
  wire wake_s  = sync2[4];
  wire osc_rise = osc_s & ~osc_d;
  wire wdt_rise = sync2[1] & ~wdt_d;

  //----------------------------------------------------------
  // Registers
  //----------------------------------------------------------
  cssr_fuse_t  fuse;
  cssr_mode_t  mode;
  cssr_state_t state;

  wire wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_en   = wb_req & wb_we_i & wb_sel_i[0];
  wire fuse_wr = wr_en & (wb_adr_i == `CSSR_FUSE_OFS);
  wire ctrl_wr = wr_en & (wb_adr_i == `CSSR_CTRL_OFS);

  //----------------------------------------------------------
  // Fuse decode
  //----------------------------------------------------------
  cssr_src_t   src;
  logic [16:0] su_cnt;
  logic [1:0]  tout_sel;
  logic [2:0]  osc_range;

  // Source kind from select code; a one bit is unprogrammed
  assign src = fuse.cksel[3]          ? SRC_LP_XTAL :
               (fuse.cksel[3:1] == 3'h3) ? SRC_FS_XTAL :
               (fuse.cksel[3:1] == 3'h2) ? SRC_LF_XTAL :
               (fuse.cksel == 4'h3)    ? SRC_RC128 :
               (fuse.cksel == 4'h2)    ? SRC_RC_CAL :
               (fuse.cksel == 4'h0)    ? SRC_EXT : SRC_RSVD;

  // Low power crystal range, shown in status
  assign osc_range = fuse.cksel[3:1];

  wire [2:0] su_idx = {fuse.cksel[0], fuse.sut};

  // Start-up count and time-out choice per source
  always_comb begin
    su_cnt   = `CSSR_SU_EXT;
    tout_sel = (fuse.sut == 2'h0) ? 2'h0 : (fuse.sut == 2'h1) ? 2'h1 : 2'h2;
    if (src == SRC_LP_XTAL || src == SRC_FS_XTAL) begin
      case (su_idx)
        3'h0:    begin su_cnt = `CSSR_SU_258; tout_sel = 2'h1; end
        3'h1:    begin su_cnt = `CSSR_SU_258; tout_sel = 2'h2; end
        3'h2:    begin su_cnt = `CSSR_SU_1K;  tout_sel = 2'h0; end
        3'h3:    begin su_cnt = `CSSR_SU_1K;  tout_sel = 2'h1; end
        3'h4:    begin su_cnt = `CSSR_SU_1K;  tout_sel = 2'h2; end
        3'h5:    begin su_cnt = 17'(SU_16K);  tout_sel = 2'h0; end
        3'h6:    begin su_cnt = 17'(SU_16K);  tout_sel = 2'h1; end
        default: begin su_cnt = 17'(SU_16K);  tout_sel = 2'h2; end
      endcase
    end else if (src == SRC_LF_XTAL) begin
      su_cnt   = fuse.cksel[0] ? 17'(SU_32K) : `CSSR_SU_1K;
      tout_sel = (fuse.sut == 2'h3) ? 2'h2 : fuse.sut;
    end
  end

  // Time-out length in watchdog cycles
  wire [13:0] tout_len = (tout_sel == 2'h0) ? 14'h0000 :
                         (tout_sel == 2'h1) ? 14'(TOUT_SHORT) : 14'(TOUT_LONG);

  //----------------------------------------------------------
  // Start-up sequencer
  //----------------------------------------------------------
  logic [13:0] tout_cnt;
  logic [16:0] ripple;
  logic        from_reset;
  cssr_state_t next_state;

  wire tout_done  = (tout_cnt >= tout_len);
  wire start_done = (ripple >= (from_reset ? su_cnt + `CSSR_ADD_CK : su_cnt));
  wire deep_sleep = (mode == MODE_PWR_DOWN) || (mode == MODE_PWR_SAVE);

  // Next state of the sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD:  if (src_ok) next_state = ST_TOUT;
      ST_TOUT:  if (tout_done) next_state = ST_START;
      ST_START: if (start_done) next_state = ST_RUN;
      ST_RUN:   if (mode != MODE_ACTIVE) next_state = ST_SLEEP;
      ST_SLEEP: if (wake_s) next_state = deep_sleep ? ST_START : ST_RUN;
      default:  next_state = ST_HOLD;
    endcase
    if (!src_ok) next_state = ST_HOLD;
  end

  // State, watchdog time-out and ripple counters
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_HOLD;
      tout_cnt   <= 14'h0000;
      ripple     <= 17'h00000;
      from_reset <= 1'b1;
    end else begin
      state      <= next_state;
      tout_cnt   <= (state == ST_TOUT) ? tout_cnt + 14'(wdt_rise) : 14'h0000;
      ripple     <= (state == ST_START) ? ripple + 17'(osc_rise) : 17'h00000;
      from_reset <= (state == ST_HOLD) | (from_reset & (state != ST_RUN));
    end
  end

  //----------------------------------------------------------
  // Software registers and bus answer
  //----------------------------------------------------------
  wire wake_clear = (state == ST_SLEEP) && wake_s;
  logic [31:0] rd_data;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fuse     <= `CSSR_FUSE_RST;
      mode     <= MODE_ACTIVE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      if (fuse_wr) fuse <= wb_dat_i[6:0];
      if (ctrl_wr) mode <= cssr_mode_t'(wb_dat_i[2:0]);
      else if (wake_clear) mode <= MODE_ACTIVE;
      wb_ack_o <= wb_req;
      wb_dat_o <= rd_data;
    end
  end

  assign rd_data = (wb_adr_i == `CSSR_FUSE_OFS) ? {25'h0, fuse} :
                   (wb_adr_i == `CSSR_CTRL_OFS) ? {29'h0, mode} :
                   (wb_adr_i == `CSSR_STAT_OFS) ?
                     {22'h0, osc_range, int_rst_n, state, src} : 32'h00000000;

  //----------------------------------------------------------
  // System clock divider
  //----------------------------------------------------------
  logic [2:0] div_cnt;
  logic       div_sel;
  cssr_gate_t gate;
  wire sys_lvl = div_sel ? osc_s : div_cnt[2];  // zero is programmed
  // Switching the source while a domain runs could cut a pulse short
  wire sys_quiet = ((state == ST_HOLD) || (state == ST_TOUT) || (state == ST_START)) &&
                   !(gate.core | gate.nvm | gate.periph | gate.conv);

  // Divider, and the divide select taken over only while no system domain runs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 3'h0;
      div_sel <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 3'(osc_rise);
      if (sys_quiet) div_sel <= fuse.div8;
    end
  end

  //----------------------------------------------------------
  // Domain gate enables per state and mode
  //----------------------------------------------------------
  cssr_gate_t want;

  always_comb begin
    want = '{default: 1'b0};
    want.async = (mode != MODE_PWR_DOWN);
    if (state == ST_RUN) begin
      want = '{default: 1'b1};
    end else if (state == ST_SLEEP) begin
      want.periph = (mode == MODE_IDLE);
      want.conv   = (mode == MODE_IDLE) || (mode == MODE_ADC_NR);
    end
    want.nvm = want.core;
  end

  // Gates change only while their clock is low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gate            <= '{default: 1'b0};
      int_rst_n       <= 1'b0;
      core_clk        <= 1'b0;
      nvm_if_clk      <= 1'b0;
      periph_clk      <= 1'b0;
      async_timer_clk <= 1'b0;
      converter_clk   <= 1'b0;
    end else begin
      if (!sys_lvl) begin
        gate.core   <= want.core;
        gate.nvm    <= want.nvm;
        gate.periph <= want.periph;
        gate.conv   <= want.conv;
      end
      if (!async_s) gate.async <= want.async;
      // A wake from deep sleep only delays the clocks, the core keeps its state
      int_rst_n       <= (state == ST_RUN) || (state == ST_SLEEP) || ((state == ST_START) && !from_reset);
      core_clk        <= sys_lvl & gate.core;
      nvm_if_clk      <= sys_lvl & gate.nvm;
      periph_clk      <= sys_lvl & gate.periph;
      converter_clk   <= sys_lvl & gate.conv;
      async_timer_clk <= async_s & gate.async;
    end
  end

endmodule : cssr_top
`default_nettype wire

// ### testbench/cssr_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Port checker
// ------------------------------
module cssr_chk (
  // Clock, reset and bus
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Sequencing and clocks
  input wire logic rst_src_n,
  input wire logic int_rst_n,
  input wire logic core_clk,
  input wire logic nvm_if_clk,
  input wire logic periph_clk,
  input wire logic converter_clk
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Bus answer timing
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack repeated");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // Domain relations
  nvm_follow_a: assert property (nvm_if_clk == core_clk)
    else $error("flash clock differs from core clock");
  core_periph_a: assert property (core_clk |-> periph_clk)
    else $error("core runs without peripherals");
  conv_dom_a: assert property (periph_clk |-> converter_clk)
    else $error("converter clock stopped");
  core_pulse_a: assert property ($rose(core_clk) |=> core_clk)
    else $error("short core clock pulse");
  // Reset sequencing
  rst_hold_a: assert property (!rst_src_n [*6] |-> !int_rst_n)
    else $error("reset released too early");
  rst_late_a: assert property ($rose(int_rst_n) |-> $past(rst_src_n, 4))
    else $error("reset released without delay");
  cover property ($rose(int_rst_n));
  cover property (periph_clk && !core_clk);
  cover property (wb_ack_o);
endmodule : cssr_chk
`default_nettype wire

// ### testbench/cssr_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Far-side oscillator sources
// ------------------------------
module cssr_osc_model #(
  parameter int OSC_HALF = 130,
  parameter int WDT_HALF = 170,
  parameter int ASY_HALF = 310
) (
  // Oscillator outputs
  output var logic osc_in_pin,
  output var logic wdt_osc_pin,
  output var logic async_osc_pin
);
  // Ceramic resonator, so slow start-up codes are legal
  initial begin
    osc_in_pin = 1'b0;
    forever #(OSC_HALF) osc_in_pin = ~osc_in_pin;
  end
  // Watchdog source times the reset time-out
  initial begin
    wdt_osc_pin = 1'b0;
    forever #(WDT_HALF) wdt_osc_pin = ~wdt_osc_pin;
  end
  // Timer source keeps running in sleep
  initial begin
    async_osc_pin = 1'b0;
    forever #(ASY_HALF) async_osc_pin = ~async_osc_pin;
  end
endmodule : cssr_osc_model
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Testbench
// ------------------------------
module tb;
  import cssr_pkg::*;
  localparam int OH = 130;
  localparam int WH = 170;
  localparam int SU = 40;
  logic mclk, arst_n, cyc, stb, we, rst_src_n, wake_pin, ack, int_rst_n;
  logic osc, wdt, asy, c0, c1, c2, c3, c4;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o;
  logic [31:0] seed = 32'hB318;
  logic [63:0] note;
  logic [63:0] notes[$];
  int errors = 0;
  int checked = 0;
  time t0;
  int dt;
  int tab[5][3] = '{'{'h22, 20, 16}, '{'h42, 20, 0}, '{'h52, 20, 8}, '{'h4E, 272, 8}, '{'h5F, 54, 0}};
  cssr_osc_model #(.OSC_HALF(OH), .WDT_HALF(WH)) u_cssr_osc_model (
    .osc_in_pin(osc), .wdt_osc_pin(wdt), .async_osc_pin(asy));
  cssr_top #(.TOUT_SHORT(8), .TOUT_LONG(16), .SU_16K(SU), .SU_32K(60)) u_cssr_top (
    .mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .osc_in_pin(osc),
    .wdt_osc_pin(wdt), .async_osc_pin(asy), .rst_src_n(rst_src_n), .wake_pin(wake_pin),
    .int_rst_n(int_rst_n), .core_clk(c0), .nvm_if_clk(c1), .periph_clk(c2),
    .async_timer_clk(c3), .converter_clk(c4));
  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [2:0] kind(input logic [3:0] c);
    case (c)
      4'h0: return 3'h5;
      4'h1: return 3'h6;
      4'h2: return 3'h4;
      4'h3: return 3'h3;
      4'h4, 4'h5: return 3'h2;
      4'h6, 4'h7: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction : kind
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp
  // Single bus cycle; a read notes {mask, expected}
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [63:0] n);
    @(posedge mclk);
    seed = xs(seed);
    if (!w) notes.push_back(n);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d | {seed[31:10], 10'h000};
    sel <= {seed[3:1], 1'b1};
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
  // Fuse set, reset source pulse, release time measured
  task automatic seq(input int f, input int su, input int tw);
    time t;
    int lo;
    lo = su * 2 * OH + tw * 2 * WH;
    xfer(1'b1, 8'h00, f, '0);
    rst_src_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_src_n <= 1'b1; // Stands in for a watched supply
    t = $time;
    wait (int_rst_n === 1'b1);
    cmp(32'h1, {31'h0, ($time - t) inside {[lo - 700 : lo + 1500]}});
  endtask : seq
  // Domain clocks seen high over 40 cycles, as {conv, async, periph, nvm, core}
  task automatic watch(input logic [4:0] e);
    logic [4:0] act;
    act = 5'h00;
    repeat (8) @(posedge mclk);
    repeat (40) begin
      @(posedge mclk);
      act = act | {c4, c3, c2, c1, c0};
    end
    cmp({27'h0, e}, {27'h0, act});
  endtask : watch
  // Read data checked against the oldest note
  always @(negedge mclk) begin
    if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
      note = notes.pop_front();
      cmp(note[31:0], dat_o & note[63:32]);
    end
  end
  task automatic summarize;
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    #2000000;
    errors++;
    summarize();
  end
  initial begin
    {cyc, stb, we, wake_pin, arst_n, rst_src_n, adr, sel, dat} = '0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    xfer(1'b0, 8'h00, 32'h0, {32'h7F, 32'h22});
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, 8'h00, {25'h0, seed[6:4], i[3:0]}, '0);
      xfer(1'b0, 8'h08, 32'h0, {32'h387, 22'h0, i[3:1], 4'h0, kind(i[3:0])});
    end
    for (int k = 0; k < 5; k++) seq(tab[k][0], tab[k][1], tab[k][2]);
    for (int m = 1; m < 5; m++) begin
      xfer(1'b1, 8'h04, m, '0);
      xfer(1'b0, 8'h04, 32'h0, {32'h7, m});
      xfer(1'b0, 8'h08, 32'h0, {32'h78, 32'h60});
      watch((m == 1) ? 5'h1C : (m == 2) ? 5'h18 : (m == 3) ? 5'h00 : 5'h08);
      @(posedge mclk);
      wake_pin <= 1'b1;
      t0 = $time;
      wait (c0 === 1'b1);
      dt = int'($time - t0) - ((m > 2) ? SU * 2 * OH : 0);
      cmp(32'h1, {31'h0, dt inside {[-700 : 1500]}});
      @(posedge mclk);
      wake_pin <= 1'b0;
      watch(5'h1F);
      xfer(1'b0, 8'h04, 32'h0, {32'h7, 32'h0});
      xfer(1'b0, 8'h08, 32'h0, {32'h78, 32'h58});
    end
    xfer(1'b1, 8'h0C, 32'hFFFFFFFF, '0);
    xfer(1'b0, 8'h0C, 32'h0, {32'hFFFFFFFF, 32'h0});
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    xfer(1'b0, 8'h00, 32'h0, {32'h7F, 32'h22});
    cmp(32'h0, {31'h0, int_rst_n});
    summarize();
  end
endmodule : tb
bind cssr_top cssr_chk u_cssr_chk (.mclk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rst_src_n,
  .int_rst_n, .core_clk, .nvm_if_clk, .periph_clk, .converter_clk);
`default_nettype wire
